// file: src/scpc_pkg.sv
// Package: constants and carrier types for the conversion and power-down control
package scpc_pkg;
   // Conversion time, ns, and derived cycles at 25 MHz (40 ns)
   localparam int CONV_TIME_NS = 1000;
   localparam int CLK_PERIOD_NS = 40;
   localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 8;
   // Length of the internal global reset pulse, cycles
   localparam int GRST_CYCLES = 4;
   localparam logic [1:0] PIN_SYNC_RESET = 2'h0;

   typedef enum logic [1:0] {
      SCPC_IDLE = 2'b00,
      SCPC_CONV = 2'b01,
      SCPC_PDN  = 2'b10,
      SCPC_GRST = 2'b11
   } scpc_state_t;

   // Synchronised pin levels
   typedef struct packed {
      logic conversion_start_in;
      logic power_down_in;
      logic io_mode_sel;
   } scpc_pins_t;

   // Status outputs
   typedef struct packed {
      logic busy;
      logic powered_down;
      logic differential_io;
      logic hold;
      logic global_reset;
   } scpc_stat_t;
endpackage

// file: src/scpc_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module scpc_pin_sync
   import scpc_pkg::*;
#(
   parameter int W = 3
) (
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   input wire logic [W-1:0] pin_i,
   output logic [W-1:0] level_o
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] lvl;
   } scpc_sync_t;

   scpc_sync_t st_r;
   scpc_sync_t st_nxt;

   always_comb begin
      st_nxt = st_r;
      st_nxt.s1 = pin_i;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      // Level moves only once stages two and three agree
      for (int i = 0; i < W; i++) begin
         if (st_r.s2[i] == st_r.s3[i]) begin
            st_nxt.lvl[i] = st_r.s3[i];
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign level_o = st_r.lvl;
endmodule

// file: src/scpc_ctrl.sv
// Conversion sequencing and power-down control, top level
`timescale 1ns/1ps
module scpc_ctrl
   import scpc_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   input wire logic conversion_start_in_i,
   input wire logic power_down_in_i,
   input wire logic io_mode_sel_i,
   output logic busy_o,
   output logic powered_down_o,
   output logic differential_io_o,
   output logic sample_hold_o,
   output logic conv_done_o,
   output logic global_reset_o
);
   // -----------------------------------------------------------------
   // Pin synchronisation
   // -----------------------------------------------------------------
   scpc_pins_t pins;

   scpc_pin_sync #(
      .W(3)
   ) u_sync (
      .ref_clk_i(ref_clk_i),
      .resetn_i(resetn_i),
      .pin_i({conversion_start_in_i, power_down_in_i, io_mode_sel_i}),
      .level_o(pins)
   );

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   typedef struct packed {
      scpc_state_t state;
      logic [CNT_W-1:0] cnt;
      logic cnv_prev;
      logic pd_prev;
      logic pd_armed;
      logic pd_pending;
      scpc_stat_t stat;
      logic done;
   } scpc_ctrl_t;

   scpc_ctrl_t st_r;
   scpc_ctrl_t st_nxt;

   logic cnv_rise;
   logic pd_rise;

   assign cnv_rise = pins.conversion_start_in & ~st_r.cnv_prev;
   assign pd_rise = pins.power_down_in & ~st_r.pd_prev;

   always_comb begin
      st_nxt = st_r;
      st_nxt.cnv_prev = pins.conversion_start_in;
      st_nxt.pd_prev = pins.power_down_in;
      st_nxt.done = 1'b0;
      st_nxt.stat.differential_io = pins.io_mode_sel;
      // Second power-down rise outside a conversion, with no conversion start since the first
      if (pd_rise && st_r.state != SCPC_GRST) begin
         if (st_r.pd_armed && st_r.state != SCPC_CONV) begin
            st_nxt.state = SCPC_GRST;
            st_nxt.cnt = CNT_W'(GRST_CYCLES - 1);
            st_nxt.pd_armed = 1'b0;
         end else begin
            st_nxt.pd_armed = 1'b1;
         end
      end
      unique case (st_r.state)
         SCPC_IDLE: begin
            if (st_nxt.state == SCPC_GRST) begin
               st_nxt.state = SCPC_GRST;
            end else if (pins.power_down_in) begin
               st_nxt.state = SCPC_PDN;
            end else if (cnv_rise) begin
               // One edge samples both channels at once
               st_nxt.state = SCPC_CONV;
               st_nxt.cnt = CNT_W'(CONV_CYCLES - 1);
               st_nxt.pd_armed = 1'b0;
            end
         end
         SCPC_CONV: begin
            if (pd_rise) begin
               st_nxt.pd_pending = 1'b1;
            end
            if (st_r.cnt == '0) begin
               st_nxt.done = 1'b1;
               st_nxt.state = (pins.power_down_in || st_r.pd_pending) ?
                  SCPC_PDN : SCPC_IDLE;
               st_nxt.pd_pending = 1'b0;
            end else begin
               st_nxt.cnt = st_r.cnt - 1'b1;
            end
         end
         SCPC_PDN: begin
            // Start edges are dropped, not queued
            if (st_nxt.state == SCPC_GRST) begin
               st_nxt.state = SCPC_GRST;
            end else if (!pins.power_down_in) begin
               st_nxt.state = SCPC_IDLE;
            end
         end
         SCPC_GRST: begin
            if (st_r.cnt == '0) begin
               st_nxt.state = SCPC_IDLE;
            end else begin
               st_nxt.cnt = st_r.cnt - 1'b1;
            end
            st_nxt.pd_armed = 1'b0;
            st_nxt.pd_pending = 1'b0;
         end
      endcase
      st_nxt.stat.busy = (st_nxt.state == SCPC_CONV);
      st_nxt.stat.hold = (st_nxt.state == SCPC_CONV);
      st_nxt.stat.powered_down = (st_nxt.state == SCPC_PDN);
      st_nxt.stat.global_reset = (st_nxt.state == SCPC_GRST);
   end

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign busy_o = st_r.stat.busy;
   assign powered_down_o = st_r.stat.powered_down;
   assign differential_io_o = st_r.stat.differential_io;
   assign sample_hold_o = st_r.stat.hold;
   assign conv_done_o = st_r.done;
   assign global_reset_o = st_r.stat.global_reset;
endmodule

// file: test/scpc_assertions.sv
// Port checks for the conversion and power-down control
`timescale 1ns/1ps
module scpc_assertions
   import scpc_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   input wire logic conversion_start_in_i,
   input wire logic power_down_in_i,
   input wire logic io_mode_sel_i,
   input wire logic busy_o,
   input wire logic powered_down_o,
   input wire logic differential_io_o,
   input wire logic sample_hold_o,
   input wire logic conv_done_o,
   input wire logic global_reset_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!resetn_i);
   a_start_to_busy: assert property ($rose(conversion_start_in_i) && !busy_o && !powered_down_o
      && !global_reset_o && !power_down_in_i |-> ##[4:6] $rose(busy_o))
      else $error("start edge not taken");
   a_hold_busy: assert property (sample_hold_o == busy_o)
      else $error("hold differs from busy");
   a_busy_len: assert property ($rose(busy_o) |-> ##25 $fell(busy_o))
      else $error("busy length wrong");
   a_busy_full: assert property ($fell(busy_o) |-> $past(busy_o, 25) && !$past(busy_o, 26))
      else $error("busy not held whole");
   a_done_fall: assert property ($fell(busy_o) == conv_done_o)
      else $error("done not with busy fall");
   a_pd_blocks: assert property ($rose(busy_o) |-> !$past(powered_down_o))
      else $error("start while powered down");
   a_pd_waits: assert property (!(busy_o && powered_down_o))
      else $error("powered down mid conversion");
   a_pd_after: assert property ($fell(busy_o) && power_down_in_i && $past(power_down_in_i, 6)
      |-> powered_down_o)
      else $error("no power down after conversion");
   a_grst_len: assert property ($rose(global_reset_o) |-> global_reset_o [*4] ##1 !global_reset_o)
      else $error("global reset length wrong");
   a_grst_idle: assert property (global_reset_o |-> !busy_o && !powered_down_o)
      else $error("state kept in global reset");
   a_io_mode: assert property ((!global_reset_o && $stable(io_mode_sel_i)) [*8]
      |-> differential_io_o == io_mode_sel_i)
      else $error("io mode not followed");
   c_conv: cover property ($rose(busy_o));
   c_pdn: cover property ($rose(powered_down_o));
   c_grst: cover property ($rose(global_reset_o));
endmodule
bind scpc_ctrl scpc_assertions u_chk (.*);

// file: test/scpc_host_model.sv
// Host pin driver model
`timescale 1ns/1ps
module scpc_host_model (
   input wire logic clk_i,
   output logic start_o,
   output logic pd_o,
   output logic mode_o
);
   initial begin
      start_o = 1'b0;
      pd_o = 1'b0;
      mode_o = 1'b1; // Changed only while no conversion runs
   end
   // Long pulse, the pin filter needs agreement
   task automatic pulse;
      @(negedge clk_i) start_o = 1'b1; // One request per result pair
      repeat (8) @(negedge clk_i);
      start_o = 1'b0;
   endtask
   task automatic set_pd(input logic v);
      @(negedge clk_i) pd_o = v;
   endtask
   task automatic set_mode(input logic v);
      @(negedge clk_i) mode_o = v;
   endtask
endmodule

// file: test/testbench.sv
// Self-checking bench for the conversion and power-down control
`timescale 1ns/1ps
module testbench;
   import scpc_pkg::*;
   logic ref_clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic st, pd, md, busy, pdn, dio, sh, done, grst;
   int failures = 0;
   int compares = 0;
   int run = 0;
   int last = 0;
   int nconv = 0;
   int ndone = 0;
   scpc_host_model u_host (.clk_i(ref_clk_i), .start_o(st), .pd_o(pd), .mode_o(md));
   scpc_ctrl u_dut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .conversion_start_in_i(st),
      .power_down_in_i(pd), .io_mode_sel_i(md), .busy_o(busy), .powered_down_o(pdn),
      .differential_io_o(dio), .sample_hold_o(sh), .conv_done_o(done), .global_reset_o(grst));
   initial forever #20 ref_clk_i = ~ref_clk_i;
   // Busy run length, kept at each fall
   always @(posedge ref_clk_i) begin
      chk("hold", busy, sh);
      if (done === 1'b1) ndone <= ndone + 1;
      if (busy === 1'b1) run <= run + 1;
      else if (run != 0) begin
         last <= run;
         nconv <= nconv + 1;
         run <= 0;
      end
   end
   task automatic chk(input string n, input logic e, input logic g);
      compares++;
      if (g !== e) begin
         failures++;
         $display("ERROR %s expected %b seen %b", n, e, g);
      end
   endtask
   task automatic test_done;
      if (failures == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge ref_clk_i);
   endtask
   task automatic t_conv;
      u_host.pulse();
      idle(40);
      chk("busy_len", 1'b1, last == CONV_CYCLES);
      chk("conv_count", 1'b1, nconv == 1);
   endtask
   task automatic t_pd_ignore;
      u_host.set_pd(1'b1);
      idle(8);
      chk("pdn", 1'b1, pdn);
      u_host.pulse();
      idle(8);
      chk("ignored", 1'b1, nconv == 1 && busy === 1'b0);
      u_host.set_pd(1'b0);
      idle(8);
      chk("wake", 1'b0, pdn);
   endtask
   task automatic t_pd_during;
      u_host.pulse();
      u_host.set_pd(1'b1);
      chk("not_yet", 1'b0, pdn);
      idle(30);
      chk("pdn_after", 1'b1, pdn && nconv == 2);
   endtask
   task automatic t_grst;
      int n;
      u_host.set_pd(1'b0);
      idle(8);
      u_host.set_pd(1'b1);
      for (n = 0; n < 20 && grst !== 1'b1; n++) idle(1);
      chk("grst", 1'b1, grst);
      chk("grst_state", 1'b0, busy | pdn);
      u_host.set_pd(1'b0);
      idle(12);
      u_host.pulse();
      idle(40);
      chk("restart", 1'b1, nconv == 3);
      chk("done_count", 1'b1, ndone == nconv);
   endtask
   task automatic t_mode;
      u_host.set_mode(1'b0);
      idle(8);
      chk("mode_low", 1'b0, dio);
      u_host.set_mode(1'b1);
      idle(8);
      chk("mode_high", 1'b1, dio);
   endtask
   initial begin
      idle(2);
      resetn_i = 1'b1;
      idle(8);
      chk("mode", 1'b1, dio);
      t_conv();
      t_pd_ignore();
      t_pd_during();
      t_grst();
      t_mode();
      test_done();
   end
   initial begin
      #40000;
      failures++;
      test_done();
   end
endmodule
